// >>> rtl/wep_pkg.sv
// Package: constants and types of the wake event power sequencer
package wep_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_EVT   = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0c;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CT_TGT_LO  = 0;  // Target state code [2:0]
    localparam int CT_GO      = 3;  // Command strobe, not stored
    localparam int CT_RESTORE = 4;  // Go to S0 on AC return if on (S0, S1 or S3) before loss
    localparam int CT_PME_EN  = 5;  // pm_event_wake_enable
    localparam int CT_S5_LAN  = 6;  // Network wake from S5
    localparam int CT_S5_PME  = 7;  // Bus PM event wake from S5
    localparam int CT_DUAL    = 8;  // Indicator is dual coloured
    localparam logic [8:0] CTRL_RST = 9'h000;
    // ----------------------------------------
    // State codes and input indices
    // ----------------------------------------
    localparam logic [2:0] SC_S0 = 3'h0;
    localparam logic [2:0] SC_S1 = 3'h1;
    localparam logic [2:0] SC_S3 = 3'h3;
    localparam logic [2:0] SC_S4 = 3'h4;
    localparam logic [2:0] SC_S5 = 3'h5;
    localparam int IN_LAN  = 0;
    localparam int IN_RING = 1;
    localparam int IN_USB  = 2;
    localparam int IN_KBD  = 3;
    localparam int IN_PME  = 4;
    localparam int IN_PCIE = 5;
    localparam int IN_BTN  = 6;
    localparam int IN_AC   = 7;
    localparam int NEV     = 8;  // Event bits, same order
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ   = 25_000_000;
    localparam int unsigned DEB_MS   = 10;
    localparam int unsigned LONG_SEC = 4;
    localparam int unsigned DEB_CYC  = CLK_HZ / 1000 * DEB_MS;
    localparam int unsigned LONG_CYC = CLK_HZ * LONG_SEC;
    // Power states
    typedef enum logic [2:0] {PS_S0, PS_S1, PS_S3, PS_S4, PS_S5} wep_state_t;
endpackage

// >>> rtl/wep_sequencer.sv
// Wake event power sequencer with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module wep_sequencer
    import wep_pkg::*;
#(
    parameter int unsigned DEB_CYCLES  = DEB_CYC,
    parameter int unsigned LONG_CYCLES = LONG_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        lan_wake,
    input  wire logic        modem_ring,
    input  wire logic        usb_activity,
    input  wire logic        kbd_activity,
    input  wire logic        pm_event_n,
    input  wire logic        pcie_wake_n,
    input  wire logic        pwr_btn_n,
    input  wire logic        ac_ok,
    output logic             supply_on,
    output logic      [1:0]  fan_en,
    output logic             led_amber,
    output logic             led_green,
    output logic             irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [NEV-1:0] sync1_r, sync2_r, prev_r; // Synchronizer and edge
    logic [NEV-1:0] lvl, rise;                // Active-high levels
    wep_state_t     state_r;                  // Power state
    logic [8:0]     ctrl_r;                   // Control register
    logic [NEV-1:0] evt_r, mask_r, evt_set;   // Sticky events, mask
    logic           was_on_r;                 // On before AC loss
    logic           wr_pend_r;                // Write data phase due
    logic [7:0]     wr_addr_r;                // Write address
    logic [31:0]    hrdata_r;                 // Read data
    logic           btn_db_r, btn_prev_r;     // Debounced button
    logic [17:0]    deb_cnt_r;                // Debounce count
    logic [26:0]    hold_cnt_r;               // Press length
    logic           long_done_r;              // Long press taken
    logic           long_hit, short_go;       // Button decisions
    logic           acc, cmd_go, cmd_ok;      // Bus and command
    logic           s13, s134, s5;            // State groups
    logic [NEV-1:0] wk;                       // Qualified wakes
    logic           wake_go;                  // Any wake taken
    logic           ac_fall, ac_rise;         // AC edges
    wep_state_t     cmd_st;                   // Commanded state

    // Code of a state as software sees it
    function automatic logic [2:0] st_code(input wep_state_t s);
        unique case (s)
            PS_S0:   st_code = SC_S0;
            PS_S1:   st_code = SC_S1;
            PS_S3:   st_code = SC_S3;
            PS_S4:   st_code = SC_S4;
            PS_S5:   st_code = SC_S5;
            default: st_code = SC_S5;
        endcase
    endfunction

    // ----------------------------------------
    // Input synchronizers
    // ----------------------------------------
    // Two flops per pin before any logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 8'h70;  // Idle levels, low-active pins high
            sync2_r <= 8'h70;
        end else begin
            sync1_r <= {ac_ok, pwr_btn_n, pcie_wake_n, pm_event_n,
                        kbd_activity, usb_activity, modem_ring, lan_wake};
            sync2_r <= sync1_r;
        end
    end

    // Normalise polarity
    assign lvl = sync2_r ^ 8'h70;

    // Edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 8'h00;
        end else begin
            prev_r <= lvl;
        end
    end

    assign rise    = lvl & ~prev_r;
    assign ac_fall = ~lvl[IN_AC] & prev_r[IN_AC];
    assign ac_rise = rise[IN_AC];

    // ----------------------------------------
    // Power button
    // ----------------------------------------
    // Debounce: level taken after stable run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deb_cnt_r <= 18'h00000;
            btn_db_r  <= 1'b0;
        end else if (lvl[IN_BTN] == btn_db_r) begin
            deb_cnt_r <= 18'h00000;
        end else if (deb_cnt_r == 18'(DEB_CYCLES - 1)) begin
            deb_cnt_r <= 18'h00000;
            btn_db_r  <= lvl[IN_BTN];
        end else begin
            deb_cnt_r <= deb_cnt_r + 18'h00001;
        end
    end

    // Press length, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt_r  <= 27'h0000000;
            long_done_r <= 1'b0;
            btn_prev_r  <= 1'b0;
        end else begin
            btn_prev_r <= btn_db_r;
            if (!btn_db_r) begin
                hold_cnt_r  <= 27'h0000000;
                long_done_r <= 1'b0;
            end else if (long_hit) begin
                long_done_r <= 1'b1;
            end else if (!long_done_r) begin
                hold_cnt_r <= hold_cnt_r + 27'h0000001;
            end
        end
    end

    // Long fires once while held; short on release
    assign long_hit = btn_db_r && !long_done_r
                      && hold_cnt_r == 27'(LONG_CYCLES - 1);
    assign short_go = btn_prev_r && !btn_db_r && !long_done_r;

    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    assign s13  = state_r == PS_S1 || state_r == PS_S3;
    assign s134 = s13 || state_r == PS_S4;
    assign s5   = state_r == PS_S5;

    // Each source gated by state, LAN and PME also by enables
    always_comb begin
        wk          = '0;
        wk[IN_LAN]  = rise[IN_LAN] && (s134 || s5 && ctrl_r[CT_S5_LAN]);
        wk[IN_RING] = rise[IN_RING] && s13;
        wk[IN_USB]  = rise[IN_USB] && s13;
        wk[IN_KBD]  = rise[IN_KBD] && s13;
        wk[IN_PME]  = rise[IN_PME] && ctrl_r[CT_PME_EN]
                      && (s134 || s5 && ctrl_r[CT_S5_PME]);
        wk[IN_PCIE] = rise[IN_PCIE] && (s134 || s5);
    end

    assign wake_go = |wk && lvl[IN_AC];

    // Software command decode
    always_comb begin
        cmd_st = PS_S5;
        cmd_ok = 1'b1;
        unique case (hwdata[CT_TGT_LO +: 3])
            SC_S1:   cmd_st = PS_S1;
            SC_S3:   cmd_st = PS_S3;
            SC_S4:   cmd_st = PS_S4;
            SC_S5:   cmd_st = PS_S5;
            default: cmd_ok = 1'b0;
        endcase
    end

    assign cmd_go = wr_pend_r && wr_addr_r == OFS_CTRL && hwdata[CT_GO]
                    && cmd_ok && state_r == PS_S0 && lvl[IN_AC];

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    // Priority: AC, long press, short press, wake, software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= PS_S5;
        end else if (!lvl[IN_AC]) begin
            state_r <= PS_S5;
        end else if (ac_rise) begin
            state_r <= (ctrl_r[CT_RESTORE] && was_on_r) ? PS_S0 : PS_S5;
        end else if (long_hit) begin
            state_r <= PS_S5;
        end else if (short_go) begin
            state_r <= (state_r == PS_S0) ? PS_S1 : PS_S0;
        end else if (wake_go) begin
            state_r <= PS_S0;
        end else if (cmd_go) begin
            state_r <= cmd_st;
        end
    end

    // Remember on/off while AC is good
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            was_on_r <= 1'b0;
        end else if (lvl[IN_AC] && !ac_rise) begin
            was_on_r <= state_r != PS_S5 && state_r != PS_S4;
        end
    end

    // Supply, fans, indicator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_on <= 1'b0;
            fan_en    <= 2'b00;
            led_amber <= 1'b0;
            led_green <= 1'b0;
        end else begin
            supply_on <= state_r == PS_S0 || state_r == PS_S1;
            fan_en    <= {2{state_r == PS_S0 || state_r == PS_S1}};
            led_amber <= state_r == PS_S3 && ctrl_r[CT_DUAL];
            led_green <= state_r == PS_S0 || state_r == PS_S1;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign acc = hsel && htrans[1] && hready;

    // Address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h00000000;
        end else begin
            wr_pend_r <= acc && hwrite;
            if (acc) begin
                wr_addr_r <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                unique case (haddr[7:0])
                    OFS_CTRL:  hrdata_r <= {23'h000000, ctrl_r};
                    OFS_STATE: hrdata_r <= {29'h00000000, st_code(state_r)};
                    OFS_EVT:   hrdata_r <= {24'h000000, evt_r};
                    OFS_MASK:  hrdata_r <= {24'h000000, mask_r};
                    default:   hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // Zero-wait, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;

    // Control and mask writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
            mask_r <= 8'h00;
        end else if (wr_pend_r) begin
            if (wr_addr_r == OFS_CTRL) begin
                ctrl_r <= hwdata[8:0] & 9'h1f0;
            end
            if (wr_addr_r == OFS_MASK) begin
                mask_r <= hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    // Qualified wakes, button press and AC return; the button slot of wk is never set
    assign evt_set = {ac_rise, short_go | long_hit, wk[IN_PCIE:0]};

    // Sticky, read clears, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_r <= 8'h00;
        end else if (acc && !hwrite && haddr[7:0] == OFS_EVT) begin
            evt_r <= evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_r & mask_r);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_fan_working: assert property (
        (state_r == PS_S0 || state_r == PS_S1) |=> fan_en == 2'b11)
        else $error("fans off in working state");
    a_fan_sleeping: assert property (
        (state_r inside {PS_S3, PS_S4, PS_S5}) |=> fan_en == 2'b00 && !supply_on)
        else $error("fans or supply on while asleep");
    a_ac_restore: assert property (
        ac_rise && ctrl_r[CT_RESTORE] && was_on_r |=> state_r == PS_S0 ##1 supply_on)
        else $error("on state not restored");
    a_ac_loss: assert property (
        ac_fall |=> state_r == PS_S5 ##1 !supply_on)
        else $error("supply kept on after mains loss");
    a_sw_off: assert property (
        cmd_go && cmd_st == PS_S5 && !long_hit && !short_go && !wake_go && !ac_rise
        |=> state_r == PS_S5 ##1 !supply_on)
        else $error("soft off did not drop supply");
    a_ring_gate: assert property (
        state_r == PS_S4 && rise[IN_RING] && !rise[IN_PCIE] && !rise[IN_LAN]
        && !rise[IN_PME] && !short_go && !long_hit && lvl[IN_AC] && !ac_rise
        |=> state_r == PS_S4)
        else $error("ring woke from wrong state");
    a_usb_gate: assert property (
        state_r == PS_S5 && rise[IN_USB] && !rise[IN_PCIE] && !rise[IN_LAN]
        && !rise[IN_PME] && !short_go && !long_hit && lvl[IN_AC] && !ac_rise
        |=> state_r == PS_S5)
        else $error("usb woke from soft off");
    a_pme_enable: assert property (
        state_r == PS_S4 && !ctrl_r[CT_PME_EN] && rise[IN_PME] && !rise[IN_PCIE]
        && !rise[IN_LAN] && !short_go && !long_hit && lvl[IN_AC] && !ac_rise
        |=> state_r == PS_S4)
        else $error("pm event wake while disabled");
    a_pcie_wake: assert property (
        state_r == PS_S4 && rise[IN_PCIE] && lvl[IN_AC] && !ac_rise
        && !long_hit && !short_go |=> state_r == PS_S0 ##1 fan_en == 2'b11)
        else $error("express wake not taken");
    a_s3_panel: assert property (
        state_r == PS_S3 |=> !supply_on && led_amber == $past(ctrl_r[CT_DUAL]))
        else $error("bad supply or indicator in S3");
    a_long_off: assert property (
        long_hit && lvl[IN_AC] && !ac_rise |=> state_r == PS_S5)
        else $error("long press did not force off");
    a_deb_settle: assert property (
        $changed(btn_db_r) |-> $past(deb_cnt_r) == 18'(DEB_CYCLES - 1))
        else $error("button changed before debounce");

    c_s3_wake: cover property (state_r == PS_S3 ##1 state_r == PS_S0);
    c_long_press: cover property (long_hit ##1 state_r == PS_S5);
    c_ac_restore: cover property (ac_rise ##1 state_r == PS_S0);
    c_irq: cover property ($rose(irq));
endmodule // wep_sequencer
`default_nettype wire

// >>> bench/wep_far_side.sv
// Far-side model: wake sources, power switch and AC mains
`timescale 1ns/1ps
`default_nettype none
module wep_far_side
    import wep_pkg::*;
(
    input  wire logic hclk,
    output logic      lan_wake,
    output logic      modem_ring,
    output logic      usb_activity,
    output logic      kbd_activity,
    output logic      pm_event_n,
    output logic      pcie_wake_n,
    output logic      pwr_btn_n,
    output logic      ac_ok
);
    // ----------------------------------------
    // Idle levels: active-high lines low, active-low lines high
    // ----------------------------------------
    initial begin
        lan_wake     = 1'b0;
        modem_ring   = 1'b0;
        usb_activity = 1'b0;
        kbd_activity = 1'b0;
        pm_event_n   = 1'b1;
        pcie_wake_n  = 1'b1;
        pwr_btn_n    = 1'b1;
        ac_ok        = 1'b1;  // Mains present from power-up
    end

    // Drive one source to its active or idle level
    task automatic set_src(input int idx, input logic on);
        case (idx)
            IN_LAN:  lan_wake     <= on;
            IN_RING: modem_ring   <= on;
            IN_USB:  usb_activity <= on;
            IN_KBD:  kbd_activity <= on;
            IN_PME:  pm_event_n   <= ~on;
            default: pcie_wake_n  <= ~on;
        endcase
    endtask

    // Assert a wake source for four cycles, then release it
    task automatic wake(input int idx);
        @(posedge hclk);
        set_src(idx, 1'b1);
        repeat (4) @(posedge hclk);
        set_src(idx, 1'b0);
    endtask

    // Hold the power switch down for a number of cycles
    task automatic press(input int n);
        @(posedge hclk);
        pwr_btn_n <= 1'b0;
        repeat (n) @(posedge hclk);
        pwr_btn_n <= 1'b1;
    endtask

    // Mains good or lost
    task automatic mains(input logic level);
        @(posedge hclk);
        ac_ok <= level;
    endtask
endmodule // wep_far_side
`default_nettype wire

// >>> bench/tb_wake_event_power_sequencer.sv
// Testbench of the wake event power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_wake_event_power_sequencer
    import wep_pkg::*;
;
    // ----------------------------------------
    // Bus, pins and bookkeeping
    // ----------------------------------------
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, fan_en;
    logic [2:0]  hsize;
    logic        lan_wake, modem_ring, usb_activity, kbd_activity;
    logic        pm_event_n, pcie_wake_n, pwr_btn_n, ac_ok;
    logic        supply_on, led_amber, led_green;
    logic [4:0]  cfg;        // Stored control bits 8:4
    int          fails, cmp_count, cyc;

    wep_sequencer #(.DEB_CYCLES(4), .LONG_CYCLES(50)) u_wep_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .lan_wake(lan_wake), .modem_ring(modem_ring), .usb_activity(usb_activity),
        .kbd_activity(kbd_activity), .pm_event_n(pm_event_n), .pcie_wake_n(pcie_wake_n),
        .pwr_btn_n(pwr_btn_n), .ac_ok(ac_ok), .supply_on(supply_on), .fan_en(fan_en),
        .led_amber(led_amber), .led_green(led_green), .irq(irq));

    wep_far_side u_wep_far_side (
        .hclk(hclk), .lan_wake(lan_wake), .modem_ring(modem_ring),
        .usb_activity(usb_activity), .kbd_activity(kbd_activity),
        .pm_event_n(pm_event_n), .pcie_wake_n(pcie_wake_n),
        .pwr_btn_n(pwr_btn_n), .ac_ok(ac_ok));

    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("mismatches=%0d comparisons=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    // Software command, settings kept
    task automatic go(input logic [2:0] code);
        wr(OFS_CTRL, {23'h0, cfg, 1'b1, code});
    endtask

    task automatic setcfg;
        wr(OFS_CTRL, {23'h0, cfg, 4'h0});
    endtask

    task automatic wk(input int idx);
        u_wep_far_side.wake(idx);
        repeat (6) @(posedge hclk);
    endtask

    task automatic btn(input int n);
        u_wep_far_side.press(n);
        repeat (20) @(posedge hclk);
    endtask

    task automatic pw(input logic level);
        u_wep_far_side.mains(level);
        repeat (10) @(posedge hclk);
    endtask

    // State code and every power output for one state
    task automatic st(input logic [2:0] code);
        logic [31:0] d;
        logic        on;
        on = (code == SC_S0) || (code == SC_S1);
        repeat (2) @(posedge hclk);
        rd(OFS_STATE, d);
        chk(d, {29'h0, code});
        chk(supply_on, on);
        chk(fan_en, {2{on}});
        chk(led_green, on);
        chk(led_amber, (code == SC_S3) && cfg[4]);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        st(SC_S5);
        rd(OFS_CTRL, d);
        chk(d, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, d);
        chk(d, 32'h0);
        chk(hresp, 1'b0);
        chk(irq, 1'b0);
        wr(OFS_MASK, 32'h80);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1);
        rd(OFS_EVT, d);
        chk(d, 32'h80);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
    endtask

    task automatic t_button;
        logic [31:0] d;
        btn(20);
        st(SC_S0);
        rd(OFS_EVT, d);
        chk(d, 32'h40);
        btn(2);
        st(SC_S0);
        btn(20);
        st(SC_S1);
        btn(20);
        st(SC_S0);
    endtask

    task automatic t_sleep;
        logic [31:0] d;
        go(3'h2);
        st(SC_S0);
        go(SC_S1);
        st(SC_S1);
        wk(IN_USB);
        st(SC_S0);
        cfg[CT_DUAL - 4] = 1'b1;
        go(SC_S3);
        st(SC_S3);
        wk(IN_KBD);
        st(SC_S0);
        wr(OFS_MASK, 32'h02);
        rd(OFS_EVT, d);
        go(SC_S3);
        wk(IN_RING);
        st(SC_S0);
        chk(irq, 1'b1);
        rd(OFS_EVT, d);
        chk(d, 32'h02);
    endtask

    task automatic t_deep;
        go(SC_S4);
        wk(IN_RING);
        wk(IN_USB);
        wk(IN_KBD);
        wk(IN_PME);
        st(SC_S4);
        wk(IN_PCIE);
        st(SC_S0);
        go(SC_S5);
        wk(IN_PCIE);
        st(SC_S0);
    endtask

    task automatic t_pme_lan;
        cfg[CT_PME_EN - 4] = 1'b1;
        go(SC_S1);
        wk(IN_PME);
        st(SC_S0);
        go(SC_S4);
        wk(IN_PME);
        st(SC_S0);
        go(SC_S5);
        st(SC_S5);
        wk(IN_PME);
        wk(IN_LAN);
        wk(IN_USB);
        st(SC_S5);
        cfg[CT_S5_PME - 4] = 1'b1;
        setcfg;
        wk(IN_PME);
        st(SC_S0);
        go(SC_S3);
        wk(IN_LAN);
        st(SC_S0);
        go(SC_S5);
        cfg[CT_S5_LAN - 4] = 1'b1;
        setcfg;
        wk(IN_LAN);
        st(SC_S0);
    endtask

    task automatic t_long_ac;
        btn(80);
        st(SC_S5);
        btn(20);
        cfg[CT_DUAL - 4] = 1'b0;
        go(SC_S3);
        st(SC_S3);
        btn(80);
        st(SC_S5);
        btn(20);
        cfg[CT_RESTORE - 4] = 1'b1;
        setcfg;
        pw(1'b0);
        st(SC_S5);
        pw(1'b1);
        st(SC_S0);
        cfg[CT_RESTORE - 4] = 1'b0;
        setcfg;
        pw(1'b0);
        pw(1'b1);
        st(SC_S5);
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        hresetn   = 1'b0;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'h2;
        hwdata    = 32'h0;
        cfg       = 5'h00;
        fails     = 0;
        cmp_count = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        t_reset;
        t_button;
        t_sleep;
        t_deep;
        t_pme_lan;
        t_long_ac;
        report_and_stop;
    end

    initial cyc = 0;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop;
        end
    end
endmodule // tb_wake_event_power_sequencer
`default_nettype wire
